//--- rtl/icd_pkg.sv
/*
 * Constants for the instruction decode and dispatch block: register
 * offsets, control and status bit positions, opcode field encodings.
 * Assumes a 32-bit AHB-Lite register bus and a 20 MHz hclk.
 */
package icd_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_OPERAND = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_DECODE = 8'h18;
  localparam logic [7:0] ADDR_MSTEP = 8'h1C;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [7:0] ADDR_WMASK = 8'h24;
  localparam logic [7:0] ADDR_TBASE = 8'h28;
  // Control bits
  localparam int CTRL_SUPER = 0;
  localparam int CTRL_FEF = 1;
  localparam int CTRL_FPU = 2;
  localparam int CTRL_CP = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  // Status / mask bits
  localparam int ST_ILLEGAL = 0;
  localparam int ST_PRIV = 1;
  localparam int ST_FPDIS = 2;
  localparam int ST_CPDIS = 3;
  localparam int ST_FPLAUNCH = 4;
  localparam int ST_CPLAUNCH = 5;
  localparam int ST_W = 6;
  // Major opcodes
  localparam logic [1:0] OP_FMT2 = 2'b00;
  localparam logic [1:0] OP_ARITH = 2'b10;
  localparam logic [1:0] OP_MEM = 2'b11;
  localparam logic [2:0] OP2_UNIMPLEMENTED_INSTR = 3'b000;
  // Minor opcodes of the arithmetic group handled here
  localparam logic [5:0] RD_MSTEP = 6'h28;
  localparam logic [5:0] RD_STATE = 6'h29;
  localparam logic [5:0] RD_WMASK = 6'h2A;
  localparam logic [5:0] RD_TBASE = 6'h2B;
  localparam logic [5:0] WR_MSTEP = 6'h30;
  localparam logic [5:0] WR_STATE = 6'h31;
  localparam logic [5:0] WR_WMASK = 6'h32;
  localparam logic [5:0] WR_TBASE = 6'h33;
  localparam logic [5:0] FLOAT_OP1 = 6'h34;
  localparam logic [5:0] FLOAT_OP2 = 6'h35;
  localparam logic [5:0] COPROC_OP1 = 6'h36;
  localparam logic [5:0] COPROC_OP2 = 6'h37;
  localparam logic [5:0] INSTR_FLUSH = 6'h3B;
  // Memory group: alternate-space offset and class bits
  localparam logic [5:0] ALT_SPACE = 6'h10;
  localparam logic [1:0] MEM_FLOAT = 2'b10;
  localparam logic [1:0] MEM_COPROC = 2'b11;
endpackage : icd_pkg

//--- rtl/icd_decode.sv
/*
 * Instruction decode and dispatch for control register access,
 * float/coprocessor launch, miscellaneous and load/store decode.
 * Software issues an instruction by writing the instruction register
 * over AHB-Lite; it executes in that write's data-phase cycle.
 * Assumes the flush-trap pin is asynchronous to hclk.
 */
// Behaviour
// - Control register accesses complete in one cycle
// - State, window, trap base need supervisor
// - Target control register chosen by opcode
// - Float/coprocessor launch takes one cycle
// - No FPU or flag clear: float disabled
// - No coprocessor attached: coprocessor disabled trap
// - Only major and minor opcode decoded
// - Float operations never stall integer pipeline
// - Unimplemented opcode raises illegal trap, one cycle
// - Instruction flush normally acts as no-op
// - Flush with trap pin low: illegal
// - Memory format fields extracted per bit layout
// - Integer memory minor opcodes decoded
// - Float and coprocessor memory opcodes decoded
`timescale 1ns/1ps
`default_nettype none
module icd_decode (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic flush_trap_input_n,
  output logic float_launch,
  output logic coproc_launch,
  output logic [31:0] launch_instr,
  output logic irq
);
  logic wr_ph_reg, rd_ph_reg; // Bus phase capture
  logic [7:0] addr_reg; // Offset held for the data phase
  logic ft_s1_reg, ft_s2_reg; // Flush-trap pin synchroniser
  logic [31:0] instr_reg, operand_reg, result_reg, decode_reg; // Software-visible words
  logic [3:0] ctrl_reg; // Supervisor, float enable, units present
  logic [icd_pkg::ST_W-1:0] status_reg, mask_reg, ev; // Sticky events, mask, new events
  logic [31:0] mstep_reg, state_reg, wmask_reg, tbase_reg; // Integer unit control registers
  logic ex, sup, alt, imm; // Execute strobe, mode and instruction bits
  logic [1:0] op; // Major opcode
  logic [5:0] op3; // Minor opcode field
  logic is_unimplemented_instr, is_flush, is_float_operate_instr, is_coproc_operate_instr, is_ctl, is_priv, mem_ok; // Opcode classes
  logic trap_ill, trap_priv, trap_fp, trap_cp, do_ctl; // Trap events and control strobe

  // Always ready, never an error: nothing stalls behind a float op
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (hready) begin
      wr_ph_reg <= hsel & htrans[1] & hwrite;
      rd_ph_reg <= hsel & htrans[1] & ~hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // Two-stage synchroniser for the flush-trap pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ft_s1_reg <= 1'b1;
      ft_s2_reg <= 1'b1;
    end else begin
      ft_s1_reg <= flush_trap_input_n;
      ft_s2_reg <= ft_s1_reg;
    end
  end

  // Instruction executes in the data phase of its write
  assign ex = wr_ph_reg && addr_reg == icd_pkg::ADDR_INSTR;
  assign op = hwdata[31:30];
  assign op3 = hwdata[24:19];
  assign sup = ctrl_reg[icd_pkg::CTRL_SUPER];
  assign alt = op3[5:4] == icd_pkg::ALT_SPACE[5:4];
  assign imm = hwdata[13];

  // Opcode classes, major and minor fields only
  always_comb begin
    is_unimplemented_instr = op == icd_pkg::OP_FMT2 && hwdata[24:22] == icd_pkg::OP2_UNIMPLEMENTED_INSTR;
    is_flush = op == icd_pkg::OP_ARITH && op3 == icd_pkg::INSTR_FLUSH;
    is_float_operate_instr = op == icd_pkg::OP_ARITH && (op3 == icd_pkg::FLOAT_OP1 ||
              op3 == icd_pkg::FLOAT_OP2);
    is_coproc_operate_instr = op == icd_pkg::OP_ARITH && (op3 == icd_pkg::COPROC_OP1 ||
              op3 == icd_pkg::COPROC_OP2);
    is_ctl = op == icd_pkg::OP_ARITH && (op3 inside {icd_pkg::RD_MSTEP,
             icd_pkg::RD_STATE, icd_pkg::RD_WMASK, icd_pkg::RD_TBASE,
             icd_pkg::WR_MSTEP, icd_pkg::WR_STATE, icd_pkg::WR_WMASK,
             icd_pkg::WR_TBASE});
    is_priv = is_ctl && op3 != icd_pkg::RD_MSTEP && // Multiply-step is unprivileged
              op3 != icd_pkg::WR_MSTEP;
  end

  // Valid memory minor opcodes, base and alternate forms
  always_comb begin
    unique case (op3)
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h07, 6'h09, 6'h0A, 6'h0D: mem_ok = 1'b1;
      6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h17, 6'h19, 6'h1A, 6'h1D: mem_ok = 1'b1;
      6'h20, 6'h21, 6'h23, 6'h27: mem_ok = 1'b1;
      6'h30, 6'h31, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37: mem_ok = 1'b1;
      default: mem_ok = 1'b0;
    endcase
  end

  // Trap and launch events of the executing instruction
  always_comb begin
    trap_ill = 1'b0;
    trap_priv = 1'b0;
    trap_fp = 1'b0;
    trap_cp = 1'b0;
    if (ex) begin
      if (is_unimplemented_instr || (is_flush && !ft_s2_reg)) begin
        trap_ill = 1'b1;
      end
      if (is_priv && !sup) begin
        trap_priv = 1'b1;
      end
      if (is_float_operate_instr || (op == icd_pkg::OP_MEM && op3[5:4] == icd_pkg::MEM_FLOAT
          && mem_ok)) begin
        trap_fp = !(ctrl_reg[icd_pkg::CTRL_FPU] &&
                    ctrl_reg[icd_pkg::CTRL_FEF]);
      end
      if (is_coproc_operate_instr || (op == icd_pkg::OP_MEM && op3[5:4] == icd_pkg::MEM_COPROC
          && mem_ok)) begin
        trap_cp = !ctrl_reg[icd_pkg::CTRL_CP];
      end
      if (op == icd_pkg::OP_MEM && (!mem_ok || (alt && imm))) begin
        trap_ill = 1'b1;
      end
    end
  end

  assign do_ctl = ex && is_ctl && !(is_priv && !sup);

  // Event vector feeding the sticky status bits
  always_comb begin
    ev = '0;
    ev[icd_pkg::ST_ILLEGAL] = trap_ill;
    ev[icd_pkg::ST_PRIV] = trap_priv;
    ev[icd_pkg::ST_FPDIS] = trap_fp;
    ev[icd_pkg::ST_CPDIS] = trap_cp;
    ev[icd_pkg::ST_FPLAUNCH] = ex && is_float_operate_instr && !trap_fp;
    ev[icd_pkg::ST_CPLAUNCH] = ex && is_coproc_operate_instr && !trap_cp;
  end

  // One-cycle launch pulse and instruction hand-off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      float_launch <= 1'b0;
      coproc_launch <= 1'b0;
      launch_instr <= 32'h0000_0000;
    end else begin
      float_launch <= ev[icd_pkg::ST_FPLAUNCH];
      coproc_launch <= ev[icd_pkg::ST_CPLAUNCH];
      if (ev[icd_pkg::ST_FPLAUNCH] || ev[icd_pkg::ST_CPLAUNCH]) begin
        launch_instr <= hwdata;
      end
    end
  end

  // Control register reads and writes, one cycle each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mstep_reg <= 32'h0000_0000;
      state_reg <= 32'h0000_0000;
      wmask_reg <= 32'h0000_0000;
      tbase_reg <= 32'h0000_0000;
      result_reg <= 32'h0000_0000;
    end else if (do_ctl) begin
      unique case (op3)
        icd_pkg::RD_MSTEP: result_reg <= mstep_reg;
        icd_pkg::RD_STATE: result_reg <= state_reg;
        icd_pkg::RD_WMASK: result_reg <= wmask_reg;
        icd_pkg::RD_TBASE: result_reg <= tbase_reg;
        icd_pkg::WR_MSTEP: mstep_reg <= operand_reg;
        icd_pkg::WR_STATE: state_reg <= operand_reg;
        icd_pkg::WR_WMASK: wmask_reg <= operand_reg;
        default: tbase_reg <= operand_reg;
      endcase
    end
  end

  // Memory decode: fields of the last memory instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      decode_reg <= 32'h0000_0000;
    end else if (ex && op == icd_pkg::OP_MEM) begin
      decode_reg[5:0] <= op3;
      decode_reg[6] <= alt;
      decode_reg[7] <= imm;
      decode_reg[15:8] <= alt ? hwdata[12:5] : 8'h00;
      decode_reg[20:16] <= hwdata[18:14];
      decode_reg[25:21] <= imm ? 5'h00 : hwdata[4:0];
      decode_reg[30:26] <= hwdata[29:25];
      decode_reg[31] <= mem_ok && !(alt && imm);
    end
  end

  // Software writes of instruction, operand, control and mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_reg <= 32'h0000_0000;
      operand_reg <= 32'h0000_0000;
      ctrl_reg <= icd_pkg::CTRL_RESET;
      mask_reg <= '0;
    end else if (wr_ph_reg) begin
      unique case (addr_reg)
        icd_pkg::ADDR_INSTR: instr_reg <= hwdata;
        icd_pkg::ADDR_OPERAND: operand_reg <= hwdata;
        icd_pkg::ADDR_CTRL: ctrl_reg <= hwdata[3:0];
        icd_pkg::ADDR_MASK: mask_reg <= hwdata[icd_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status, cleared by a read; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
    end else if (rd_ph_reg && addr_reg == icd_pkg::ADDR_STATUS) begin
      status_reg <= ev;
    end else begin
      status_reg <= status_reg | ev;
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_ph_reg) begin
      unique case (addr_reg)
        icd_pkg::ADDR_INSTR: hrdata = instr_reg;
        icd_pkg::ADDR_OPERAND: hrdata = operand_reg;
        icd_pkg::ADDR_RESULT: hrdata = result_reg;
        icd_pkg::ADDR_CTRL: hrdata[3:0] = ctrl_reg;
        icd_pkg::ADDR_STATUS: hrdata[icd_pkg::ST_W-1:0] = status_reg;
        icd_pkg::ADDR_MASK: hrdata[icd_pkg::ST_W-1:0] = mask_reg;
        icd_pkg::ADDR_DECODE: hrdata = decode_reg;
        icd_pkg::ADDR_MSTEP: hrdata = mstep_reg;
        icd_pkg::ADDR_STATE: hrdata = state_reg;
        icd_pkg::ADDR_WMASK: hrdata = wmask_reg;
        icd_pkg::ADDR_TBASE: hrdata = tbase_reg;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Supervisor write lands next cycle
  state_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_ctl && op3 == icd_pkg::WR_STATE && sup
    |=> state_reg == $past(operand_reg))
    else $error("state write not done in one cycle");

  // User write leaves target intact and flags privilege
  user_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_ctl && op3 == icd_pkg::WR_TBASE && !sup
    |=> $stable(tbase_reg) && status_reg[icd_pkg::ST_PRIV])
    else $error("user write reached trap base");

  // Multiply-step stays reachable in user mode
  user_mstep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == icd_pkg::OP_ARITH && op3 == icd_pkg::RD_MSTEP
    |-> !trap_priv)
    else $error("multiply-step read wrongly privileged");

  // Read selects register named by opcode
  read_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_ctl && op3 == icd_pkg::RD_WMASK && sup
    |=> result_reg == $past(wmask_reg))
    else $error("wrong register read");

  // Launch pulse only follows an enabled float op
  launch_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    float_launch |-> $past(ex) && $past(is_float_operate_instr) && $past(ctrl_reg[icd_pkg::CTRL_FEF]))
    else $error("launch without enabled float op");

  // Float op with enable flag clear traps, no launch
  float_dis_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_float_operate_instr && !ctrl_reg[icd_pkg::CTRL_FEF]
    |=> !float_launch ##0 status_reg[icd_pkg::ST_FPDIS])
    else $error("float disabled trap missing");

  // Coprocessor op without unit traps
  cp_dis_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_coproc_operate_instr && !ctrl_reg[icd_pkg::CTRL_CP]
    |=> !coproc_launch && status_reg[icd_pkg::ST_CPDIS])
    else $error("coprocessor disabled trap missing");

  // Unimplemented opcode sets illegal
  unimplemented_instr_trap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_unimplemented_instr |=> status_reg[icd_pkg::ST_ILLEGAL])
    else $error("unimplemented opcode did not trap");

  // Flush with pin high is a no-op
  flush_nop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_flush && ft_s2_reg |-> ev == '0)
    else $error("flush did not act as no-op");

  // Flush with pin low traps
  flush_trap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && is_flush && !ft_s2_reg |=> status_reg[icd_pkg::ST_ILLEGAL])
    else $error("flush did not trap");

  // Alternate with immediate decodes illegal
  alt_imm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ex && op == icd_pkg::OP_MEM && alt && imm
    |=> !decode_reg[31] && status_reg[icd_pkg::ST_ILLEGAL])
    else $error("alternate immediate form accepted");
endmodule : icd_decode
`default_nettype wire

//--- dv/icd_fpu_model.sv
/*
 * Behavioural float unit and coprocessor that sit behind the launch port.
 * Assumes launches arrive as one-cycle pulses on hclk with the word beside them.
 */
`timescale 1ns/1ps
`default_nettype none
module icd_fpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic float_launch,
  input wire logic coproc_launch,
  input wire logic [31:0] launch_instr,
  output logic [7:0] float_count,
  output logic [7:0] coproc_count,
  output logic [31:0] queue_front
);
  // Float unit accepts every cycle, so the issuer never waits on it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      float_count <= 8'h00;
      queue_front <= 32'h0000_0000;
    end else if (float_launch) begin
      float_count <= float_count + 8'h01;
      // Whole word kept; fields past the opcodes are ours to read
      queue_front <= launch_instr;
    end
  end

  // Coprocessor side, same prompt acceptance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coproc_count <= 8'h00;
    end else if (coproc_launch) begin
      coproc_count <= coproc_count + 8'h01;
    end
  end
endmodule // icd_fpu_model
`default_nettype wire

//--- dv/testbench.sv
/*
 * Self-checking bench: AHB-Lite single-word tasks issue instructions.
 * Assumes the decoder answers with hreadyout and executes on INSTR writes.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, launch_instr, queue_front, v, w;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic flush_trap_input_n, float_launch, coproc_launch;
  logic [7:0] float_count, coproc_count, ef, ec;
  int fails, check_count, i;
  // Launch cases: control value, opcode, expected status bit
  logic [3:0] lc [7] = '{4'h7, 4'h7, 4'h5, 4'h3, 4'h9, 4'h9, 4'h1};
  logic [5:0] lo [7] = '{icd_pkg::FLOAT_OP1, icd_pkg::FLOAT_OP2, icd_pkg::FLOAT_OP1,
    icd_pkg::FLOAT_OP1, icd_pkg::COPROC_OP1, icd_pkg::COPROC_OP2, icd_pkg::COPROC_OP1};
  int ls [7] = '{4, 4, 2, 2, 5, 5, 3};
  // Memory minor opcodes: ten integer ones first
  logic [5:0] mc [21] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h09, 6'h0A, 6'h0D, 6'h04, 6'h05,
    6'h07, 6'h20, 6'h21, 6'h23, 6'h27, 6'h30, 6'h31, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37};

  assign hready = hreadyout;

  icd_decode icd_decode_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .flush_trap_input_n, .float_launch,
    .coproc_launch, .launch_instr, .irq);
  icd_fpu_model icd_fpu_model_i (.hclk, .hresetn, .float_launch, .coproc_launch,
    .launch_instr, .float_count, .coproc_count, .queue_front);

  // Clock, 50 ns period
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Wait for hready at a rising edge; only the watchdog ends a hang
  task automatic wait_rdy;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b1;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read a register and compare; data and response taken at the data-phase end edge
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'b00;
    wait_rdy();
    chk({31'h0, hresp}, 32'h0);
    chk(hrdata, exp);
  endtask

  task automatic ex(input logic [31:0] word);
    wr(icd_pkg::ADDR_INSTR, word);
  endtask

  task automatic sts(input logic [31:0] exp);
    rchk(icd_pkg::ADDR_STATUS, exp);
  endtask

  // One memory instruction and its decode fields
  task automatic mem(input logic [5:0] op, input logic alt);
    logic [31:0] e;
    e = {1'b1, 5'd3, 5'd9, 5'd17, alt ? 8'hC6 : 8'h00, 1'b0, alt, op};
    ex({2'b11, 5'd3, op, 5'd17, 1'b0, 8'hC6, 5'd9});
    rchk(icd_pkg::ADDR_DECODE, e);
    sts(32'h0);
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    flush_trap_input_n = 1'b1;
    ef = 8'h00;
    ec = 8'h00;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(icd_pkg::ADDR_CTRL, 32'h0000_0001);
    sts(32'h0);
    rchk(8'h3C, 32'h0);
    $display("test reset done");
    // Supervisor writes then reads of each control register
    for (i = 0; i < 4; i++) begin
      v = 32'h1234_5670 + 32'(i);
      wr(icd_pkg::ADDR_OPERAND, v);
      ex({2'b10, 5'd0, icd_pkg::WR_MSTEP + 6'(i), 19'h0});
      rchk(icd_pkg::ADDR_MSTEP + 8'(4 * i), v);
      ex({2'b10, 5'd0, icd_pkg::RD_MSTEP + 6'(i), 19'h0});
      rchk(icd_pkg::ADDR_RESULT, v);
    end
    $display("test supervisor access done");
    // User mode: privileged ones trap and leave the target alone
    wr(icd_pkg::ADDR_CTRL, 32'h0);
    wr(icd_pkg::ADDR_OPERAND, 32'hDEAD_0000);
    for (i = 1; i < 4; i++) begin
      ex({2'b10, 5'd0, icd_pkg::WR_MSTEP + 6'(i), 19'h0});
      rchk(icd_pkg::ADDR_MSTEP + 8'(4 * i), 32'h1234_5670 + 32'(i));
      sts(32'h1 << icd_pkg::ST_PRIV);
      ex({2'b10, 5'd0, icd_pkg::RD_MSTEP + 6'(i), 19'h0});
      sts(32'h1 << icd_pkg::ST_PRIV);
    end
    ex({2'b10, 5'd0, icd_pkg::WR_MSTEP, 19'h0});
    rchk(icd_pkg::ADDR_MSTEP, 32'hDEAD_0000);
    sts(32'h0);
    $display("test user access done");
    // Float and coprocessor launch or disabled trap
    for (i = 0; i < 7; i++) begin
      w = {2'b10, 5'd21, lo[i], 5'd7, 9'h1A5, 5'd30};
      wr(icd_pkg::ADDR_CTRL, {28'h000_0000, lc[i]});
      ex(w);
      sts(32'h1 << ls[i]);
      if (ls[i] == icd_pkg::ST_FPLAUNCH) ef++;
      if (ls[i] == icd_pkg::ST_CPLAUNCH) ec++;
      if (ls[i] > icd_pkg::ST_CPDIS) chk(launch_instr, w);
      chk({16'h0000, float_count, coproc_count}, {16'h0000, ef, ec});
    end
    chk(queue_front, {2'b10, 5'd21, icd_pkg::FLOAT_OP2, 5'd7, 9'h1A5, 5'd30});
    $display("test launch done");
    // Unimplemented and flush, with and without the trap pin
    ex({2'b00, 5'd0, 3'b000, 22'h0_0123});
    sts(32'h1 << icd_pkg::ST_ILLEGAL);
    ex({2'b10, 5'd0, icd_pkg::INSTR_FLUSH, 19'h0});
    sts(32'h0);
    flush_trap_input_n <= 1'b0;
    repeat (3) @(posedge hclk);
    ex({2'b10, 5'd0, icd_pkg::INSTR_FLUSH, 19'h0});
    sts(32'h1 << icd_pkg::ST_ILLEGAL);
    flush_trap_input_n <= 1'b1;
    repeat (3) @(posedge hclk);
    $display("test misc done");
    // Memory decode, all units present so only the alternate immediate form traps
    wr(icd_pkg::ADDR_CTRL, 32'h0000_000F);
    for (i = 0; i < 21; i++) begin
      mem(mc[i], 1'b0);
      if (i < 10) mem(mc[i] | icd_pkg::ALT_SPACE, 1'b1);
    end
    ex({2'b11, 5'd3, 6'h00, 5'd17, 1'b1, 13'h1ABC});
    rchk(icd_pkg::ADDR_DECODE, {1'b1, 5'd3, 5'd0, 5'd17, 8'h00, 1'b1, 1'b0, 6'h00});
    ex({2'b11, 5'd3, 6'h10, 5'd17, 1'b1, 13'h1ABC});
    sts(32'h1 << icd_pkg::ST_ILLEGAL);
    $display("test memory decode done");
    // Interrupt raised, cleared by status read, then masked
    wr(icd_pkg::ADDR_MASK, 32'h1 << icd_pkg::ST_ILLEGAL);
    ex({2'b00, 5'd0, 3'b000, 22'h0_0001});
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    sts(32'h1 << icd_pkg::ST_ILLEGAL);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    wr(icd_pkg::ADDR_CTRL, 32'h0);
    ex({2'b10, 5'd0, icd_pkg::WR_STATE, 19'h0});
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    sts(32'h1 << icd_pkg::ST_PRIV);
    $display("test interrupt done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
